// file: plh_pkg.sv
package plh_pkg;
  localparam int CLK_MHZ = 125;
  localparam int HS_TIMEOUT_MS = 360;
  localparam int SILENT_US = 60;
  localparam int LFPS_RDY_US = 80;
  localparam int HS_TIMEOUT_CYC = HS_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int SILENT_CYC = SILENT_US * CLK_MHZ;
  localparam int LFPS_RDY_CYC = LFPS_RDY_US * CLK_MHZ;
  localparam int TMR_W = 26;
  localparam int RDY_W = 14;
  localparam logic [4:0] TX_MIN_BASE = 5'h10;
  localparam logic [4:0] TX_NO_SCD = 5'h14;
  localparam logic [4:0] NOSIG_MAX = 5'h10;
  localparam logic [4:0] RX_CONSEC = 5'h02;
  localparam logic [4:0] AFTER_BASE = 5'h04;
  localparam logic [4:0] AFTER_SCD = 5'h02;
  localparam logic [1:0] PTO_MAX = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LFPS = 3'h2,
    ST_PLUS = 3'h4
  } plh_state_t;

  typedef enum logic [1:0] {
    TX_OFF = 2'h0,
    TX_LFPS = 2'h1,
    TX_SCD1 = 2'h2,
    TX_SCD2 = 2'h3
  } plh_tx_t;

  typedef enum logic [2:0] {
    EX_NONE = 3'h0,
    EX_RXEQ = 3'h1,
    EX_PORTMATCH = 3'h2,
    EX_CMPL = 3'h3,
    EX_RXDET = 3'h4,
    EX_INACTIVE = 3'h5,
    EX_DISABLED = 3'h6
  } plh_exit_t;

  // Saturating increment shared by all burst counters
  function automatic logic [4:0] plh_sat(input logic [4:0] v, input logic [4:0] lim);
    return (v >= lim) ? lim : 5'(v + 5'h01);
  endfunction : plh_sat
endpackage : plh_pkg

// file: plh_tmr_if.sv
interface plh_tmr_if;
  logic run;
  logic expired;
  modport ctl (output run, input expired);
  modport tmr (input run, output expired);
endinterface : plh_tmr_if

// file: plh_timer.sv
module plh_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  plh_tmr_if.tmr tif
);
  localparam int W = plh_pkg::TMR_W;
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] cnt_q;

  // Restarts whenever run drops; holds at the limit once expired
  always_ff @(posedge i_clk) begin
    if (i_srst || !tif.run) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM) begin
      cnt_q <= W'(cnt_q + 1'b1);
    end
  end

  assign tif.expired = tif.run && (cnt_q == LIM);
endmodule : plh_timer

// file: plh_pto_cnt.sv
module plh_pto_cnt (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [1:0] o_cnt
);
  logic [1:0] cnt_q;

  // An increment in the same cycle as a clear wins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= 2'h0;
    end else if (i_inc) begin
      cnt_q <= (cnt_q == plh_pkg::PTO_MAX) ? plh_pkg::PTO_MAX : 2'(cnt_q + 2'h1);
    end else if (i_clr) begin
      cnt_q <= 2'h0;
    end
  end

  assign o_cnt = cnt_q;
endmodule : plh_pto_cnt

// file: plh_fsm.sv
module plh_fsm #(
  parameter int unsigned P_HS_CYC = plh_pkg::HS_TIMEOUT_CYC,
  parameter int unsigned P_SILENT_CYC = plh_pkg::SILENT_CYC,
  parameter int unsigned P_RDY_CYC = plh_pkg::LFPS_RDY_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_is_dfp,
  input wire logic i_is_hub,
  input wire logic i_ssp_cap,
  input wire logic i_enter,
  input wire logic i_lfps_ready,
  input wire logic i_warm_rst,
  input wire logic i_dir_disable,
  input wire logic i_cmpl_dir,
  input wire logic i_us_warm_rst,
  input wire logic i_exit_u0,
  input wire logic i_term_removed,
  input wire logic i_tx_done,
  input wire logic i_rx_burst,
  input wire logic i_rx_sig_scd1,
  input wire logic i_rx_sig_scd2,
  input wire logic i_rx_seq_scd1,
  input wire logic i_rx_seq_scd2,
  input wire logic i_rx_lfps_active,
  output logic [2:0] o_state,
  output logic o_lfps_rx_en,
  output logic o_lfps_late,
  output logic [1:0] o_tx_mode,
  output logic o_ssp,
  output logic o_exit_vld,
  output logic [2:0] o_exit_code,
  output logic o_cmpl_en,
  output logic o_trained,
  output logic [1:0] o_pto_cnt
);
  plh_pkg::plh_state_t st_q;
  plh_pkg::plh_exit_t ex_d, ex_q;
  plh_pkg::plh_tx_t tx_mode_d, tx_mode_q;
  logic to_d, to_q, to_plus, success;
  logic ssp_q, fb_q, cmpl_q, trained_q, late_q, base_hs_q;
  logic got_q, seen_q;
  logic [4:0] tx_q, rx_q, after_q, nosig_q;
  logic [plh_pkg::RDY_W-1:0] rdy_q;
  logic active, silent, hs_exp, sig_now, base_ok, scd_ok, lfps_drop, plus_drop;

  plh_tmr_if hs_tif();
  plh_tmr_if sil_tif();

  assign active = (st_q != plh_pkg::ST_IDLE);
  assign hs_tif.run = active;
  assign sil_tif.run = active && ssp_q && base_hs_q && !i_rx_lfps_active;
  assign hs_exp = hs_tif.expired;
  assign silent = sil_tif.expired;

  plh_timer #(.LIMIT(P_HS_CYC)) u_hs_tmr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .tif(hs_tif.tmr)
  );

  plh_timer #(.LIMIT(P_SILENT_CYC)) u_sil_tmr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .tif(sil_tif.tmr)
  );

  plh_pto_cnt u_pto (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_inc(to_q && i_is_dfp && (ex_q == plh_pkg::EX_RXDET)),
    .i_clr(i_us_warm_rst || i_exit_u0 || i_term_removed ||
           (ex_q == plh_pkg::EX_INACTIVE) || (ex_q == plh_pkg::EX_DISABLED)),
    .o_cnt(o_pto_cnt)
  );

  assign base_ok = (tx_q >= plh_pkg::TX_MIN_BASE) && (rx_q >= plh_pkg::RX_CONSEC) &&
                   (after_q >= plh_pkg::AFTER_BASE);
  assign scd_ok = got_q && (after_q >= plh_pkg::AFTER_SCD);
  assign lfps_drop = (rx_q >= plh_pkg::RX_CONSEC) && (tx_q >= plh_pkg::TX_NO_SCD) &&
                     !seen_q && silent;
  assign plus_drop = silent && (tx_q >= plh_pkg::TX_NO_SCD) && !seen_q;
  assign sig_now = (st_q == plh_pkg::ST_LFPS) ? i_rx_sig_scd1 : i_rx_sig_scd2;

  // Exit selection: directives first, then handshakes, then the timeout
  always_comb begin
    ex_d = plh_pkg::EX_NONE;
    to_d = 1'b0;
    to_plus = 1'b0;
    case (st_q)
      plh_pkg::ST_LFPS, plh_pkg::ST_PLUS: begin
        if (i_is_dfp && i_dir_disable) begin
          ex_d = plh_pkg::EX_DISABLED;
        end else if (i_warm_rst) begin
          ex_d = plh_pkg::EX_RXDET;
        end else if (st_q == plh_pkg::ST_LFPS && !ssp_q && base_ok) begin
          ex_d = plh_pkg::EX_RXEQ;
        end else if (st_q == plh_pkg::ST_LFPS && ssp_q && scd_ok) begin
          to_plus = 1'b1;
        end else if (st_q == plh_pkg::ST_LFPS && ssp_q && lfps_drop) begin
          ex_d = plh_pkg::EX_RXEQ;
        end else if (st_q == plh_pkg::ST_PLUS && scd_ok) begin
          ex_d = plh_pkg::EX_PORTMATCH;
        end else if (st_q == plh_pkg::ST_PLUS && plus_drop) begin
          ex_d = plh_pkg::EX_RXEQ;
        end else if (hs_exp) begin
          to_d = 1'b1;
          if (i_is_dfp) begin
            if (st_q == plh_pkg::ST_LFPS && cmpl_q) begin
              ex_d = plh_pkg::EX_CMPL;
            end else if (o_pto_cnt == plh_pkg::PTO_MAX) begin
              ex_d = plh_pkg::EX_INACTIVE;
            end else begin
              ex_d = plh_pkg::EX_RXDET;
            end
          end else if (st_q == plh_pkg::ST_LFPS && !trained_q) begin
            ex_d = plh_pkg::EX_CMPL;
          end else begin
            ex_d = i_is_hub ? plh_pkg::EX_RXDET : plh_pkg::EX_DISABLED;
          end
        end
      end
      default: begin
      end
    endcase
  end

  assign success = to_plus || (ex_d == plh_pkg::EX_RXEQ);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= plh_pkg::ST_IDLE;
    end else begin
      case (st_q)
        plh_pkg::ST_IDLE: begin
          if (i_enter) begin
            st_q <= plh_pkg::ST_LFPS;
          end
        end
        plh_pkg::ST_LFPS: begin
          if (ex_d != plh_pkg::EX_NONE) begin
            st_q <= plh_pkg::ST_IDLE;
          end else if (to_plus) begin
            st_q <= plh_pkg::ST_PLUS;
          end
        end
        plh_pkg::ST_PLUS: begin
          if (ex_d != plh_pkg::EX_NONE) begin
            st_q <= plh_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= plh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ex_q <= plh_pkg::EX_NONE;
      to_q <= 1'b0;
    end else begin
      ex_q <= ex_d;
      to_q <= to_d;
    end
  end

  // Rate: a base-rate partner or a fallback in the LFPS substate drops the rate in the following cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ssp_q <= 1'b0;
      fb_q <= 1'b0;
    end else if (st_q == plh_pkg::ST_IDLE) begin
      fb_q <= 1'b0;
      if (i_enter) begin
        ssp_q <= i_ssp_cap;
      end
    end else begin
      if (ex_d == plh_pkg::EX_RXEQ) begin
        ssp_q <= 1'b0;
      end else if (st_q == plh_pkg::ST_LFPS && nosig_q >= plh_pkg::NOSIG_MAX) begin
        ssp_q <= 1'b0;
      end
      if (st_q == plh_pkg::ST_PLUS && nosig_q >= plh_pkg::NOSIG_MAX) begin
        fb_q <= 1'b1;
      end
    end
  end

  // Burst bookkeeping, cleared on entry to each substate and on fallback in the LFPS substate; rx_q only on entry to LFPS
  always_ff @(posedge i_clk) begin
    if (i_srst || !active || to_plus ||
        (st_q == plh_pkg::ST_LFPS && ssp_q && nosig_q >= plh_pkg::NOSIG_MAX)) begin
      tx_q <= 5'h00;
      after_q <= 5'h00;
      got_q <= 1'b0;
      seen_q <= 1'b0;
      nosig_q <= 5'h00;
      if (i_srst || !active) begin
        rx_q <= 5'h00;
      end
    end else begin
      if (i_tx_done) begin
        tx_q <= plh_pkg::plh_sat(tx_q, plh_pkg::TX_NO_SCD);
      end
      if (i_tx_done && got_q) begin
        after_q <= plh_pkg::plh_sat(after_q, plh_pkg::AFTER_BASE);
      end
      if (i_rx_burst) begin
        rx_q <= plh_pkg::plh_sat(rx_q, plh_pkg::RX_CONSEC);
        nosig_q <= sig_now ? 5'h00 : plh_pkg::plh_sat(nosig_q, plh_pkg::NOSIG_MAX);
      end
      if (!ssp_q) begin
        got_q <= got_q || i_rx_burst;
      end else if (st_q == plh_pkg::ST_LFPS) begin
        got_q <= got_q || i_rx_seq_scd1 || i_rx_seq_scd2;
        seen_q <= seen_q || i_rx_seq_scd1 || (i_rx_burst && i_rx_sig_scd1);
      end else begin
        got_q <= got_q || i_rx_seq_scd2;
        seen_q <= seen_q || i_rx_seq_scd2 || (i_rx_burst && i_rx_sig_scd2);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !active) begin
      base_hs_q <= 1'b0;
    end else if (rx_q >= plh_pkg::RX_CONSEC) begin
      base_hs_q <= 1'b1;
    end
  end

  always_comb begin
    case (st_q)
      plh_pkg::ST_LFPS: begin
        if (!ssp_q) begin
          tx_mode_d = plh_pkg::TX_LFPS;
        end else if (i_is_dfp && cmpl_q) begin
          tx_mode_d = plh_pkg::TX_SCD2;
        end else begin
          tx_mode_d = plh_pkg::TX_SCD1;
        end
      end
      plh_pkg::ST_PLUS: tx_mode_d = fb_q ? plh_pkg::TX_LFPS : plh_pkg::TX_SCD2;
      default: tx_mode_d = plh_pkg::TX_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_mode_q <= plh_pkg::TX_OFF;
    end else begin
      tx_mode_q <= tx_mode_d;
    end
  end

  // Compliance path enable; a direction to enable wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmpl_q <= !i_is_dfp;
    end else begin
      if ((i_is_dfp && i_warm_rst) || success || ex_d == plh_pkg::EX_CMPL) begin
        cmpl_q <= 1'b0;
      end
      if (i_is_dfp && i_cmpl_dir) begin
        cmpl_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      trained_q <= 1'b0;
    end else if (success) begin
      trained_q <= 1'b1;
    end
  end

  // Readiness watchdog for the low-frequency circuitry
  always_ff @(posedge i_clk) begin
    if (i_srst || !active) begin
      rdy_q <= '0;
      late_q <= 1'b0;
    end else if (!i_lfps_ready && !late_q && rdy_q != '1) begin
      rdy_q <= plh_pkg::RDY_W'(rdy_q + 1'b1);
      if (rdy_q == plh_pkg::RDY_W'(P_RDY_CYC - 1)) begin
        late_q <= 1'b1;
      end
    end
  end

  assign o_state = st_q;
  assign o_lfps_rx_en = active;
  assign o_lfps_late = late_q;
  assign o_tx_mode = tx_mode_q;
  assign o_ssp = ssp_q;
  assign o_exit_vld = (ex_q != plh_pkg::EX_NONE);
  assign o_exit_code = ex_q;
  assign o_cmpl_en = cmpl_q;
  assign o_trained = trained_q;

  property p_rx_en;
    @(posedge i_clk) disable iff (i_srst) (st_q == plh_pkg::ST_IDLE && i_enter) |=> o_lfps_rx_en;
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("receiver not enabled on entry");

  property p_late;
    @(posedge i_clk) disable iff (i_srst)
      $rose(o_lfps_late) |-> $past(rdy_q) == plh_pkg::RDY_W'(P_RDY_CYC - 1);
  endproperty
  a_late: assert property (p_late) else $error("late flag at wrong count");

  property p_cmpl_rst;
    @(posedge i_clk) i_srst |=> (o_cmpl_en == !$past(i_is_dfp));
  endproperty
  a_cmpl_rst: assert property (p_cmpl_rst) else $error("compliance enable reset wrong");

  property p_rate_drop;
    @(posedge i_clk) disable iff (i_srst) (o_exit_code == plh_pkg::EX_RXEQ) |-> !o_ssp;
  endproperty
  a_rate_drop: assert property (p_rate_drop) else $error("rate not dropped at RxEQ exit");

  property p_cmpl_clr;
    @(posedge i_clk) disable iff (i_srst)
      (success && !(i_is_dfp && i_cmpl_dir)) |=> !o_cmpl_en;
  endproperty
  a_cmpl_clr: assert property (p_cmpl_clr) else $error("compliance enable kept");

  property p_ufp_cmpl;
    @(posedge i_clk) disable iff (i_srst)
      (o_exit_code == plh_pkg::EX_CMPL && !i_is_dfp) |-> !o_trained && $past(hs_exp);
  endproperty
  a_ufp_cmpl: assert property (p_ufp_cmpl) else $error("upstream compliance entry wrong");

  property p_dfp_cmpl;
    @(posedge i_clk) disable iff (i_srst)
      (o_exit_code == plh_pkg::EX_CMPL && i_is_dfp) |-> $past(o_cmpl_en);
  endproperty
  a_dfp_cmpl: assert property (p_dfp_cmpl) else $error("downstream compliance entry wrong");

  property p_inactive;
    @(posedge i_clk) disable iff (i_srst)
      (o_exit_code == plh_pkg::EX_INACTIVE) |-> o_pto_cnt == plh_pkg::PTO_MAX;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive exit below count two");

  property p_pto_inc;
    @(posedge i_clk) disable iff (i_srst)
      (to_q && i_is_dfp && o_exit_code == plh_pkg::EX_RXDET) |=>
        o_pto_cnt == (($past(o_pto_cnt) == plh_pkg::PTO_MAX) ? plh_pkg::PTO_MAX :
                      2'($past(o_pto_cnt) + 2'h1));
  endproperty
  a_pto_inc: assert property (p_pto_inc) else $error("timeout count not advanced");
endmodule : plh_fsm

// file: plh_partner.sv
module plh_partner #(
  parameter int PER = 6
) (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  output logic o_burst,
  output logic o_sig_scd1,
  output logic o_sig_scd2,
  output logic o_seq_scd1,
  output logic o_seq_scd2,
  output logic o_active
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  // Mode 0 silent, 1 plain bursts, 2 SCD1, 3 SCD2; a full sequence every fourth burst
  always @(posedge i_clk) begin
    cnt_q <= (i_mode == 2'h0 || cnt_q == 4 * PER - 1) ? 0 : cnt_q + 1;
  end
  assign o_active = i_mode != 2'h0;
  assign o_burst = o_active && (cnt_q % PER == PER - 1);
  // Qualifiers toggle outside bursts so a stale value is never seen
  assign o_sig_scd1 = o_burst ? i_mode == 2'h2 : cnt_q[0];
  assign o_sig_scd2 = o_burst ? i_mode == 2'h3 : !cnt_q[0];
  assign o_seq_scd1 = i_mode == 2'h2 && cnt_q == 4 * PER - 1;
  assign o_seq_scd2 = i_mode == 2'h3 && cnt_q == 4 * PER - 1;
endmodule : plh_partner

// file: plh_fsm_test.sv
module plh_fsm_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HS_CYC = 400;
  logic i_clk = 1'b0;
  logic srst, dfp, hub, ssp, enter, rdy, txd;
  logic [5:0] pls;
  logic [1:0] pmode, txm, pto;
  logic burst, sig1, sig2, seq1, seq2, act;
  logic [2:0] st, code;
  logic rx_en, late, ssp_o, xv, cmpl, trained;
  int n_fail = 0;
  int comparisons = 0;
  int txc = 0;
  int cyc = 0;
  int t0 = 0;

  always #4 i_clk = ~i_clk;

  // The local transmitter finishes one burst or sequence every fourth cycle
  always @(posedge i_clk) begin
    txc <= (txc + 1) % 4;
    cyc <= cyc + 1;
    txd <= (txc == 3) && ((txm != 2'h0) === 1'b1);
  end

  plh_partner #(.PER(6)) i_partner (.i_clk(i_clk), .i_mode(pmode), .o_burst(burst),
    .o_sig_scd1(sig1), .o_sig_scd2(sig2), .o_seq_scd1(seq1), .o_seq_scd2(seq2),
    .o_active(act));

  plh_fsm #(.P_HS_CYC(HS_CYC), .P_SILENT_CYC(20), .P_RDY_CYC(16)) i_dut (
    .i_clk(i_clk), .i_srst(srst), .i_is_dfp(dfp), .i_is_hub(hub), .i_ssp_cap(ssp),
    .i_enter(enter), .i_lfps_ready(rdy), .i_warm_rst(pls[0]), .i_dir_disable(pls[1]),
    .i_cmpl_dir(pls[2]), .i_us_warm_rst(pls[3]), .i_exit_u0(pls[4]),
    .i_term_removed(pls[5]), .i_tx_done(txd), .i_rx_burst(burst), .i_rx_sig_scd1(sig1),
    .i_rx_sig_scd2(sig2), .i_rx_seq_scd1(seq1), .i_rx_seq_scd2(seq2),
    .i_rx_lfps_active(act), .o_state(st), .o_lfps_rx_en(rx_en), .o_lfps_late(late),
    .o_tx_mode(txm), .o_ssp(ssp_o), .o_exit_vld(xv), .o_exit_code(code),
    .o_cmpl_en(cmpl), .o_trained(trained), .o_pto_cnt(pto));

  task automatic chk(input string nm, input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic reset_dut(input logic d, input logic h);
    dfp <= d;
    hub <= h;
    srst <= 1'b1;
    repeat (6) @(posedge i_clk);
    srst <= 1'b0;
    tick(1);
  endtask : reset_dut

  task automatic start(input logic s, input logic [1:0] m);
    @(posedge i_clk);
    ssp <= s;
    pmode <= m;
    enter <= 1'b1;
    @(posedge i_clk);
    enter <= 1'b0;
    #1;
  endtask : start

  task automatic pulse(input int b);
    @(posedge i_clk);
    pls[b] <= 1'b1;
    @(posedge i_clk);
    pls[b] <= 1'b0;
    #1;
  endtask : pulse

  // State 0 waits for an exit pulse and checks its code, otherwise waits for that state
  task automatic wait_until(input logic [2:0] s, input logic [2:0] c);
    int n;
    n = 0;
    while ((s == 3'h0 ? xv : st == s) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (s == 3'h0) begin
      chk("exit_code", code, c);
    end else begin
      chk("state", st, s);
    end
  endtask : wait_until

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    {srst, dfp, hub, ssp, enter, rdy, pls, pmode} = '0;
    reset_dut(1'b0, 1'b0);
    chk("state", st, 3'h1);
    chk("cmpl_en", cmpl, 3'h1);
    chk("trained", trained, 3'h0);
    start(1'b0, 2'h0);
    t0 = cyc;
    chk("rx_en", rx_en, 3'h1);
    tick(20);
    chk("late", late, 3'h1);
    wait_until(3'h0, 3'h3);
    chk("hs_span", 3'(cyc - t0 == HS_CYC + 1), 3'h1);
    chk("cmpl_en", cmpl, 3'h0);
    rdy <= 1'b1;
    start(1'b0, 2'h1);
    tick(1);
    chk("tx_mode", txm, 3'h1);
    chk("late", late, 3'h0);
    wait_until(3'h0, 3'h1);
    chk("trained", trained, 3'h1);
    start(1'b0, 2'h0);
    wait_until(3'h0, 3'h6);
    hub <= 1'b1;
    start(1'b0, 2'h0);
    wait_until(3'h0, 3'h4);
    start(1'b1, 2'h1);
    tick(1);
    chk("tx_mode", txm, 3'h2);
    tick(104);
    chk("ssp", ssp_o, 3'h0);
    chk("tx_mode", txm, 3'h1);
    wait_until(3'h0, 3'h1);
    start(1'b1, 2'h1);
    tick(30);
    pmode <= 2'h0;
    wait_until(3'h0, 3'h1);
    chk("ssp", ssp_o, 3'h0);
    start(1'b1, 2'h3);
    wait_until(3'h4, 3'h0);
    tick(2);
    chk("tx_mode", txm, 3'h3);
    wait_until(3'h0, 3'h2);
    start(1'b1, 2'h2);
    t0 = cyc;
    wait_until(3'h4, 3'h0);
    tick(110);
    chk("tx_mode", txm, 3'h1);
    chk("ssp", ssp_o, 3'h1);
    wait_until(3'h0, 3'h4);
    chk("hs_span", 3'(cyc - t0 == HS_CYC + 1), 3'h1);
    start(1'b1, 2'h2);
    wait_until(3'h4, 3'h0);
    tick(20);
    pmode <= 2'h0;
    wait_until(3'h0, 3'h1);
    chk("ssp", ssp_o, 3'h0);
    start(1'b1, 2'h1);
    pulse(0);
    wait_until(3'h0, 3'h4);
    reset_dut(1'b1, 1'b0);
    chk("cmpl_en", cmpl, 3'h0);
    pulse(2);
    chk("cmpl_en", cmpl, 3'h1);
    start(1'b1, 2'h0);
    tick(1);
    chk("tx_mode", txm, 3'h3);
    wait_until(3'h0, 3'h3);
    chk("cmpl_en", cmpl, 3'h0);
    for (int i = 0; i < 3; i++) begin
      start(1'b1, 2'h0);
      tick(1);
      chk("tx_mode", txm, 3'h2);
      wait_until(3'h0, i < 2 ? 3'h4 : 3'h5);
      tick(2);
      chk("pto_cnt", pto, i < 2 ? 3'(i + 1) : 3'h0);
    end
    // Each clearing event in turn: upstream warm reset, exit to U0, termination removal
    for (int b = 3; b < 6; b++) begin
      start(1'b0, 2'h0);
      wait_until(3'h0, 3'h4);
      tick(2);
      chk("pto_cnt", pto, 3'h1);
      pulse(b);
      tick(1);
      chk("pto_cnt", pto, 3'h0);
    end
    start(1'b0, 2'h1);
    pulse(1);
    wait_until(3'h0, 3'h6);
    start(1'b0, 2'h1);
    pulse(0);
    wait_until(3'h0, 3'h4);
    report_and_stop();
  end
endmodule : plh_fsm_test
